// ### design/alarm_if.sv
`timescale 1ns/1ps
interface alarm_if #(parameter int NUM = 11);
  logic [NUM-1:0] exceed;
  logic [NUM-1:0] measure;
  logic clear;
  logic [NUM-1:0] level;
  modport tracker (input exceed, input measure, input clear, output level);
  modport owner (output exceed, output measure, output clear, input level);
endinterface

// ### design/alarm_tracker.sv
`timescale 1ns/1ps
module alarm_tracker #(
  parameter int NUM = 11
) (
  input wire logic pclk,
  input wire logic presetn,
  alarm_if.tracker alarms
);
  import hwmon_pkg::*;

  genvar i;
  generate
    for (i = 0; i < NUM; i++) begin : g_ch
      logic level_reg;
      logic level_next;
      always_comb begin
        level_next = level_reg;
        if (alarms.clear) begin
          level_next = 1'b0;
        end else if (alarms.measure[i]) begin
          level_next = alarms.exceed[i];
        end
      end
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          level_reg <= 1'b0;
        end else begin
          level_reg <= level_next;
        end
      end
      assign alarms.level[i] = level_reg;
    end
  endgenerate
endmodule

// ### design/hw_monitor_realtime_status.sv
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
// Overview of operation
// - First status bit 7 shows whether the second fan count is over its limit.
// - First status bit 6 shows whether the first fan count is over its limit.
// - First status bit 5 shows whether the first temperature reading is over its limit.
// - First status bit 4 shows whether the second temperature reading is over its limit.
// - First status bit 3 shows whether the +5V supply is outside its limit.
// - First status bit 2 shows whether the +3.3V supply is outside its limit.
// - First status bit 0 shows whether the core supply is outside its limit; bit 1 reads zero.
// - Second status bit 3 shows whether the third fan count is over its limit.
// - Second status bit 2 shows whether the -5V supply is outside its limit.
// - Second status bit 1 shows whether the -12V supply is outside its limit.
// - Second status bit 0 shows whether the +12V supply is outside its limit; bits 7 to 4 read zero.
// - The read-only second status register at index 5ah of bank 4 is zero at reset and after master reset.
// - The read-only first status register at index 59h of bank 4 is zero at reset and after master reset.
module hw_monitor_realtime_status #(
  parameter int NUM = hwmon_pkg::NUM_CH
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [hwmon_pkg::ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [hwmon_pkg::DATA_W-1:0] pwdata,
  output logic [hwmon_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NUM-1:0] channel_over_limit,
  input wire logic [NUM-1:0] channel_measured,
  input wire logic master_reset,
  output logic irq
);
  import hwmon_pkg::*;

  // Register index of an aligned in-range address
  function automatic logic [7:0] reg_index(input logic [ADDR_W-1:0] a);
    return a[9:2];
  endfunction

  // True when the address names the given register
  function automatic logic addr_hit(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
    return (a[1:0] == 2'h0) && (a[ADDR_W-1:10] == '0) && (reg_index(a) == idx);
  endfunction

  alarm_if #(.NUM(NUM)) alarms ();

  alarm_tracker #(.NUM(NUM)) u_tracker (
    .pclk(pclk),
    .presetn(presetn),
    .alarms(alarms)
  );

  // Compare results feed the tracker
  assign alarms.exceed = channel_over_limit;
  assign alarms.measure = channel_measured;
  assign alarms.clear = master_reset;

  // Named views of the tracked channels
  logic first_blower_speed_alarm;
  logic second_blower_speed_alarm;
  logic third_blower_speed_alarm;
  logic first_thermal_alarm;
  logic second_thermal_alarm;
  logic plus_five_supply_alarm;
  logic plus_three_supply_alarm;
  logic cpu_core_supply_alarm;
  logic plus_twelve_supply_alarm;
  logic minus_twelve_supply_alarm;
  logic minus_five_supply_alarm;
  logic [7:0] limit_status_first;
  logic [7:0] limit_status_second;

  assign second_blower_speed_alarm = alarms.level[CH_FAN2];
  assign first_blower_speed_alarm = alarms.level[CH_FAN1];
  assign first_thermal_alarm = alarms.level[CH_TEMP1];
  assign second_thermal_alarm = alarms.level[CH_TEMP2];
  assign plus_five_supply_alarm = alarms.level[CH_P5V];
  assign plus_three_supply_alarm = alarms.level[CH_P3V3];
  assign cpu_core_supply_alarm = alarms.level[CH_VCORE];
  assign third_blower_speed_alarm = alarms.level[CH_FAN3];
  assign minus_five_supply_alarm = alarms.level[CH_M5V];
  assign minus_twelve_supply_alarm = alarms.level[CH_M12V];
  assign plus_twelve_supply_alarm = alarms.level[CH_P12V];

  // Status register images
  always_comb begin
    limit_status_first = STATUS_RESET;
    limit_status_first[FIRST_FAN2] = second_blower_speed_alarm;
    limit_status_first[FIRST_FAN1] = first_blower_speed_alarm;
    limit_status_first[FIRST_TEMP1] = first_thermal_alarm;
    limit_status_first[FIRST_TEMP2] = second_thermal_alarm;
    limit_status_first[FIRST_P5V] = plus_five_supply_alarm;
    limit_status_first[FIRST_P3V3] = plus_three_supply_alarm;
    limit_status_first[FIRST_VCORE] = cpu_core_supply_alarm;
    limit_status_second = STATUS_RESET;
    limit_status_second[SECOND_FAN3] = third_blower_speed_alarm;
    limit_status_second[SECOND_M5V] = minus_five_supply_alarm;
    limit_status_second[SECOND_M12V] = minus_twelve_supply_alarm;
    limit_status_second[SECOND_P12V] = plus_twelve_supply_alarm;
  end

  // APB handshake
  apb_state_t state_reg;
  apb_state_t state_next;
  logic pready_reg;
  logic pready_next;
  logic pslverr_reg;
  logic pslverr_next;
  logic [DATA_W-1:0] prdata_reg;
  logic [DATA_W-1:0] prdata_next;

  // Software registers
  logic [7:0] bank_reg;
  logic [7:0] bank_next;
  logic [NUM-1:0] event_reg;
  logic [NUM-1:0] event_next;
  logic [NUM-1:0] mask_reg;
  logic [NUM-1:0] mask_next;
  logic [NUM-1:0] level_prev_reg;
  logic irq_reg;
  logic irq_next;

  logic in_status_bank;
  logic access;
  logic commit;
  logic wr_commit;
  logic known_addr;
  logic ro_addr;
  logic [NUM-1:0] rise;
  logic [NUM-1:0] clr;

  assign in_status_bank = (bank_reg[2:0] == STATUS_BANK);
  assign access = psel && penable;
  assign commit = access && pready_reg;
  assign wr_commit = commit && pwrite && !pslverr_reg;
  assign rise = alarms.level & ~level_prev_reg;

  always_comb begin
    ro_addr = in_status_bank &&
      (addr_hit(paddr, IDX_STATUS_FIRST) || addr_hit(paddr, IDX_STATUS_SECOND));
    known_addr = ro_addr || addr_hit(paddr, IDX_BANK) ||
      addr_hit(paddr, IDX_EVENT) || addr_hit(paddr, IDX_MASK);
  end

  // Handshake and read data
  always_comb begin
    state_next = state_reg;
    pready_next = 1'b0;
    pslverr_next = 1'b0;
    prdata_next = prdata_reg;
    case (state_reg)
      APB_IDLE: begin
        if (psel && !penable) begin
          state_next = APB_ACCESS;
        end
      end
      APB_ACCESS: begin
        if (access) begin
          state_next = APB_DONE;
          pready_next = 1'b1;
          pslverr_next = !known_addr || (pwrite && ro_addr);
          prdata_next = '0;
          if (!pwrite) begin
            if (in_status_bank && addr_hit(paddr, IDX_STATUS_FIRST)) begin
              prdata_next[7:0] = limit_status_first;
            end else if (in_status_bank && addr_hit(paddr, IDX_STATUS_SECOND)) begin
              prdata_next[7:0] = limit_status_second;
            end else if (addr_hit(paddr, IDX_BANK)) begin
              prdata_next[7:0] = bank_reg;
            end else if (addr_hit(paddr, IDX_EVENT)) begin
              prdata_next[NUM-1:0] = event_reg;
            end else if (addr_hit(paddr, IDX_MASK)) begin
              prdata_next[NUM-1:0] = mask_reg;
            end
          end
        end else if (!psel) begin
          state_next = APB_IDLE;
        end
      end
      APB_DONE: begin
        state_next = APB_IDLE;
      end
      default: begin
        state_next = APB_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= APB_IDLE;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= '0;
    end else begin
      state_reg <= state_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      prdata_reg <= prdata_next;
    end
  end

  // Bank, mask and sticky events
  always_comb begin
    bank_next = bank_reg;
    mask_next = mask_reg;
    clr = '0;
    if (wr_commit && addr_hit(paddr, IDX_BANK)) begin
      bank_next = pwdata[7:0];
    end
    if (wr_commit && addr_hit(paddr, IDX_MASK)) begin
      mask_next = pwdata[NUM-1:0];
    end
    if (wr_commit && addr_hit(paddr, IDX_EVENT)) begin
      clr = pwdata[NUM-1:0];
    end
    event_next = (event_reg & ~clr) | rise;
    irq_next = |(event_next & mask_next);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bank_reg <= BANK_RESET;
      mask_reg <= MASK_RESET;
      event_reg <= EVENT_RESET;
      level_prev_reg <= '0;
      irq_reg <= 1'b0;
    end else begin
      bank_reg <= bank_next;
      mask_reg <= mask_next;
      event_reg <= event_next;
      level_prev_reg <= alarms.level;
      irq_reg <= irq_next;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign irq = irq_reg;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  chk_fan2_follow: assert property (
    channel_measured[CH_FAN2] && !master_reset |=>
      limit_status_first[FIRST_FAN2] == $past(channel_over_limit[CH_FAN2]))
    else $error("fan 2 status does not follow its comparison");

  chk_fan1_follow: assert property (
    channel_measured[CH_FAN1] && !master_reset |=>
      limit_status_first[FIRST_FAN1] == $past(channel_over_limit[CH_FAN1]))
    else $error("fan 1 status does not follow its comparison");

  chk_temp1_follow: assert property (
    channel_measured[CH_TEMP1] && !master_reset |=>
      limit_status_first[FIRST_TEMP1] == $past(channel_over_limit[CH_TEMP1]))
    else $error("temperature 1 status does not follow its comparison");

  chk_temp2_follow: assert property (
    channel_measured[CH_TEMP2] && !master_reset |=>
      limit_status_first[FIRST_TEMP2] == $past(channel_over_limit[CH_TEMP2]))
    else $error("temperature 2 status does not follow its comparison");

  chk_plus_five_follow: assert property (
    channel_measured[CH_P5V] && !master_reset |=>
      limit_status_first[FIRST_P5V] == $past(channel_over_limit[CH_P5V]))
    else $error("+5V status does not follow its comparison");

  chk_plus_three_follow: assert property (
    channel_measured[CH_P3V3] && !master_reset |=>
      limit_status_first[FIRST_P3V3] == $past(channel_over_limit[CH_P3V3]))
    else $error("+3.3V status does not follow its comparison");

  chk_core_reserved: assert property (
    (channel_measured[CH_VCORE] && !master_reset |=>
      limit_status_first[FIRST_VCORE] == $past(channel_over_limit[CH_VCORE]))
      and !limit_status_first[FIRST_RSVD])
    else $error("core status wrong or reserved bit set");

  chk_fan3_follow: assert property (
    channel_measured[CH_FAN3] && !master_reset |=>
      limit_status_second[SECOND_FAN3] == $past(channel_over_limit[CH_FAN3]))
    else $error("fan 3 status does not follow its comparison");

  chk_minus_five_follow: assert property (
    channel_measured[CH_M5V] && !master_reset |=>
      limit_status_second[SECOND_M5V] == $past(channel_over_limit[CH_M5V]))
    else $error("-5V status does not follow its comparison");

  chk_minus_twelve_follow: assert property (
    channel_measured[CH_M12V] && !master_reset |=>
      limit_status_second[SECOND_M12V] == $past(channel_over_limit[CH_M12V]))
    else $error("-12V status does not follow its comparison");

  chk_twelve_reserved: assert property (
    (channel_measured[CH_P12V] && !master_reset |=>
      limit_status_second[SECOND_P12V] == $past(channel_over_limit[CH_P12V]))
      and limit_status_second[7:4] == 4'h0)
    else $error("+12V status wrong or reserved bits set");

  chk_master_clear: assert property (
    master_reset |=> limit_status_first == STATUS_RESET && limit_status_second == STATUS_RESET)
    else $error("master reset did not clear the status registers");

  chk_second_read: assert property (
    access && !pwrite && state_reg == APB_ACCESS && in_status_bank &&
      addr_hit(paddr, IDX_STATUS_SECOND) |=>
      pready && !pslverr && prdata == {24'h0, $past(limit_status_second)})
    else $error("second status read returned wrong data");

  chk_first_read: assert property (
    access && !pwrite && state_reg == APB_ACCESS && in_status_bank &&
      addr_hit(paddr, IDX_STATUS_FIRST) |=>
      pready && !pslverr && prdata == {24'h0, $past(limit_status_first)})
    else $error("first status read returned wrong data");

  chk_hold_unmeasured: assert property (
    !master_reset && channel_measured == '0 |=> $stable(alarms.level))
    else $error("status changed without a new measurement");

  chk_irq_level: assert property (
    |(event_reg & mask_reg) |-> irq)
    else $error("interrupt low while an unmasked event is pending");

  chk_irq_quiet: assert property (
    !(|(event_reg & mask_reg)) |-> !irq)
    else $error("interrupt high with no unmasked event");

  chk_pready_pulse: assert property (
    pready |=> !pready)
    else $error("pready held for more than one cycle");

  chk_status_ro_write: assert property (
    access && pwrite && state_reg == APB_ACCESS && ro_addr |=> pready && pslverr)
    else $error("write to a status register not refused");

  chk_bank_gate: assert property (
    access && !pwrite && state_reg == APB_ACCESS && !in_status_bank &&
      (addr_hit(paddr, IDX_STATUS_FIRST) || addr_hit(paddr, IDX_STATUS_SECOND)) |=>
      pready && pslverr && prdata == '0)
    else $error("status read outside its bank not refused");

endmodule

// ### design/hwmon_pkg.sv
package hwmon_pkg;
  // Channel count and bus widths
  localparam int NUM_CH = 11;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_BANK = 8'h4e;
  localparam logic [7:0] IDX_STATUS_FIRST = 8'h59;
  localparam logic [7:0] IDX_STATUS_SECOND = 8'h5a;
  localparam logic [7:0] IDX_EVENT = 8'h5b;
  localparam logic [7:0] IDX_MASK = 8'h5c;
  // Bank holding the status registers
  localparam logic [2:0] STATUS_BANK = 3'h4;
  // Reset values
  localparam logic [7:0] BANK_RESET = 8'h00;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [10:0] EVENT_RESET = 11'h000;
  localparam logic [10:0] MASK_RESET = 11'h000;
  // Channel positions in the alarm vector
  localparam int CH_VCORE = 0;
  localparam int CH_P3V3 = 1;
  localparam int CH_P5V = 2;
  localparam int CH_TEMP2 = 3;
  localparam int CH_TEMP1 = 4;
  localparam int CH_FAN1 = 5;
  localparam int CH_FAN2 = 6;
  localparam int CH_P12V = 7;
  localparam int CH_M12V = 8;
  localparam int CH_M5V = 9;
  localparam int CH_FAN3 = 10;
  // Bit positions in the first status register
  localparam int FIRST_FAN2 = 7;
  localparam int FIRST_FAN1 = 6;
  localparam int FIRST_TEMP1 = 5;
  localparam int FIRST_TEMP2 = 4;
  localparam int FIRST_P5V = 3;
  localparam int FIRST_P3V3 = 2;
  localparam int FIRST_RSVD = 1;
  localparam int FIRST_VCORE = 0;
  // Bit positions in the second status register
  localparam int SECOND_FAN3 = 3;
  localparam int SECOND_M5V = 2;
  localparam int SECOND_M12V = 1;
  localparam int SECOND_P12V = 0;
  typedef enum logic [2:0] {
    APB_IDLE = 3'b001,
    APB_ACCESS = 3'b010,
    APB_DONE = 3'b100
  } apb_state_t;
endpackage

// ### test/testbench.sv
`timescale 1ns/1ps
module testbench;
  import hwmon_pkg::*;
  localparam logic [11:0] A_BANK = {2'b00, IDX_BANK, 2'b00};
  localparam logic [11:0] A_FIRST = {2'b00, IDX_STATUS_FIRST, 2'b00};
  localparam logic [11:0] A_SECOND = {2'b00, IDX_STATUS_SECOND, 2'b00};
  localparam logic [11:0] A_EVENT = {2'b00, IDX_EVENT, 2'b00};
  localparam logic [11:0] A_MASK = {2'b00, IDX_MASK, 2'b00};
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [DATA_W-1:0] pwdata = '0;
  logic [DATA_W-1:0] prdata;
  logic pready;
  logic pslverr;
  logic [NUM_CH-1:0] channel_over_limit = '0;
  logic [NUM_CH-1:0] channel_measured = '0;
  logic master_reset = 1'b0;
  logic irq;
  int num_errors = 0;
  int num_checks = 0;
  logic [31:0] rd;
  logic err;

  hw_monitor_realtime_status #(.NUM(NUM_CH)) u_hw_monitor_realtime_status (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .channel_over_limit(channel_over_limit), .channel_measured(channel_measured),
    .master_reset(master_reset), .irq(irq)
  );

  always #5 pclk = ~pclk;

  task automatic wrap_up();
    $display("Checks %0d, errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic check(input logic [32:0] seen, input logic [32:0] exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] d, output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= wr;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    d = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      num_errors++;
      $display("MISMATCH at %0t: no pready", $time);
      wrap_up();
    end
  endtask

  // Mapping of channels onto the two status registers
  function automatic logic [15:0] exp_status(input logic [10:0] v);
    return {4'h0, v[10], v[9], v[8], v[7], v[6], v[5], v[4], v[3], v[2], v[1], 1'b0, v[0]};
  endfunction

  task automatic measure(input logic [10:0] over, input logic [10:0] meas);
    @(posedge pclk);
    channel_over_limit <= over;
    channel_measured <= meas;
    @(posedge pclk);
    channel_measured <= '0;
  endtask

  task automatic check_status(input logic [10:0] v);
    logic [15:0] x;
    x = exp_status(v);
    apb(1'b0, A_FIRST, 32'h0, rd, err);
    check({err, rd}, {1'b0, 24'h0, x[7:0]}, "first status");
    apb(1'b0, A_SECOND, 32'h0, rd, err);
    check({err, rd}, {1'b0, 24'h0, x[15:8]}, "second status");
  endtask

  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b1, A_BANK, 32'h4, rd, err);
    check_status(11'h000);
    // Each channel raised alone, then back in range
    for (int i = 0; i < NUM_CH; i++) begin
      measure(11'h1 << i, 11'h1 << i);
      check_status(11'h1 << i);
      measure(11'h0, 11'h1 << i);
      check_status(11'h0);
    end
    // All over: reserved bits stay zero
    measure(11'h7ff, 11'h7ff);
    check_status(11'h7ff);
    // Compare result moves without a strobe: no change
    measure(11'h000, 11'h000);
    check_status(11'h7ff);
    // Partial remeasure follows latest result
    measure(11'h000, 11'h555);
    check_status(11'h2aa);
    // Write to read-only status is refused
    apb(1'b1, A_FIRST, 32'hff, rd, err);
    check({31'h0, err}, 32'h1, "ro write err");
    apb(1'b1, A_SECOND, 32'h0, rd, err);
    check({31'h0, err}, 32'h1, "ro write err");
    check_status(11'h2aa);
    // Master reset clears both registers
    @(posedge pclk);
    master_reset <= 1'b1;
    @(posedge pclk);
    master_reset <= 1'b0;
    check_status(11'h000);
    // Wrong bank, unmapped and unaligned accesses
    apb(1'b1, A_BANK, 32'h0, rd, err);
    apb(1'b0, A_FIRST, 32'h0, rd, err);
    check({err, rd}, {1'b1, 32'h0}, "bank 0 read");
    apb(1'b0, 12'h000, 32'h0, rd, err);
    check({err, rd}, {1'b1, 32'h0}, "unmapped read");
    apb(1'b0, 12'h165, 32'h0, rd, err);
    check({err, rd}, {1'b1, 32'h0}, "unaligned read");
    apb(1'b1, A_BANK, 32'h4, rd, err);
    // Interrupt: clear events, unmask fan2, raise it
    apb(1'b1, A_EVENT, 32'h7ff, rd, err);
    apb(1'b1, A_MASK, 32'h040, rd, err);
    check({31'h0, irq}, 32'h0, "irq idle");
    measure(11'h040, 11'h040);
    repeat (3) @(posedge pclk);
    check({31'h0, irq}, 32'h1, "irq raised");
    apb(1'b0, A_EVENT, 32'h0, rd, err);
    check(rd, 32'h040, "event bits");
    apb(1'b1, A_EVENT, 32'h040, rd, err);
    repeat (2) @(posedge pclk);
    check({31'h0, irq}, 32'h0, "irq cleared");
    // Masked event sets its bit but no interrupt
    measure(11'h060, 11'h020);
    repeat (3) @(posedge pclk);
    check({31'h0, irq}, 32'h0, "irq masked");
    apb(1'b0, A_EVENT, 32'h0, rd, err);
    check(rd, 32'h020, "masked event");
    check_status(11'h060);
    wrap_up();
  end
endmodule
